/* File: core/cfb_fuse_bank.sv */
// configuration fuse bank: stored fuse bytes, their latched working copy,
// decoded controls for clocks, regulator, brown-out and power-up timer,
// and the program-memory write guard.
// assumes an apb master on sys_clk and a programming-mode pin from outside.
//
// Function
// RULE_01 - primary oscillator modes clock core and usb
// RULE_02 - internal core clock keeps usb on primary
// RULE_03 - regulator bit one switches usb regulator on
// RULE_04 - threshold 11 minimum, 00 maximum trip
// RULE_05 - mode 01 lets software switch brown-out
// RULE_06 - mode 00 keeps brown-out off always
// RULE_07 - power-up timer bit is active low
// RULE_08 - power-up timer independent of brown-out
// RULE_09 - block1 guard low blocks 002000-003FFF writes
// RULE_10 - block0 guard low blocks block0 range
// RULE_11 - config area guard written only programming
// RULE_12 - unimplemented bits read as zero
// RULE_13 - unprogrammed fuses show listed defaults
// RULE_14 - fuses latched at reset, held until next; here also reloaded when programming ends
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`include "cfb_defs.svh"

module cfb_fuse_bank (
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [23:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   // device side
   input  wire logic             prog_mode_pin,
   input  wire logic             in_sleep,
   input  wire logic             boot_block_large,
   input  wire logic             prog_wr_req,
   input  wire logic [21:0]      prog_wr_addr,
   output logic                  prog_wr_done,
   output logic                  prog_wr_allow,
   output cfb_pkg::cfb_src_t     cpu_clk_src,
   output cfb_pkg::cfb_src_t     usb_clk_src,
   output logic                  usb_regulator_on,
   output logic [1:0]            brownout_trip_level,
   output logic                  brownout_reset_on,
   output logic                  powerup_timer_on,
   output logic                  osc_switchover_on,
   output logic                  clock_monitor_on,
   output logic                  fuses_valid
);

   // stored (nonvolatile) fuses and the working copy the device uses
   cfb_pkg::cfb_fuse_t nv, next_nv;
   cfb_pkg::cfb_fuse_t act, next_act;
   logic load_pend, next_load_pend;        // copy owed after reset
   logic soft_brownout_on, next_soft_brownout_on;
   // programming-mode pin synchroniser and filtered level
   logic [2:0] prg_sync;
   logic prog_mode, next_prog_mode;
   // apb decode
   logic        setup;
   logic        wr_now;
   logic [7:0]  rd_byte;
   logic        hit;
   logic [7:0]  wb;

   // pin crosses in three stages; only stages two and three are compared
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prg_sync <= 3'h0;
      end else begin
         prg_sync <= {prg_sync[1:0], prog_mode_pin};
      end
   end

   // level changes only once the last two stages agree
   always_comb begin
      next_prog_mode = prog_mode;
      if (prg_sync[1] == prg_sync[2]) begin
         next_prog_mode = prg_sync[2];
      end
   end

   // setup and access phases of an apb transfer; answer comes in the access cycle
   assign setup  = psel && !penable;
   assign wr_now = psel && penable && pwrite && pready;
   assign wb     = pwdata[7:0];

   // fuse store: only writable while programming [RULE_11]
   always_comb begin
      next_nv = nv;
      next_soft_brownout_on = soft_brownout_on;
      if (wr_now) begin
         // control byte is ordinary logic, writable any time [RULE_05]
         if (paddr == `CFB_ADDR(`CFB_IDX_CTRL)) begin
            next_soft_brownout_on = wb[`CFB_CTRL_SBO_BIT];
         end
         if (prog_mode) begin
            unique case (paddr)
               `CFB_ADDR(`CFB_IDX_OSC): begin
                  next_nv.osc_switchover_on = wb[`CFB_OSC_SWO_BIT];
                  next_nv.clock_monitor_on = wb[`CFB_OSC_FCM_BIT];
                  next_nv.osc_source_sel =
                     wb[`CFB_OSC_SEL_LSB +: 4];
               end
               `CFB_ADDR(`CFB_IDX_REGBP): begin
                  next_nv.usb_regulator_on = wb[`CFB_RB_VREG_BIT];
                  next_nv.brownout_threshold_sel =
                     wb[`CFB_RB_THR_LSB +: 2];
                  next_nv.brownout_mode_sel = wb[`CFB_RB_MODE_LSB +: 2];
                  next_nv.powerup_timer_off_n = wb[`CFB_RB_POWERUP_TIMER_BIT];
               end
               `CFB_ADDR(`CFB_IDX_WPLO): begin
                  // guards can only be cleared, never set back [RULE_09]
                  next_nv.block1_guard =
                     nv.block1_guard & wb[`CFB_WP_B1_BIT];
                  next_nv.block0_guard =
                     nv.block0_guard & wb[`CFB_WP_B0_BIT]; // [RULE_10]
               end
               `CFB_ADDR(`CFB_IDX_WPHI): begin
                  next_nv.boot_block_guard =
                     nv.boot_block_guard & wb[`CFB_WP_BOOT_BIT];
                  // written freely, but only here in programming [RULE_11]
                  next_nv.config_area_guard = wb[`CFB_WP_CFG_BIT];
               end
               default: begin
                  // other addresses leave the store alone
               end
            endcase
         end
      end
   end

   // working copy reloads after reset and when programming ends
   always_comb begin
      next_load_pend = 1'b0;
      next_act = act;
      if (load_pend || (prog_mode && !next_prog_mode)) begin
         next_act = nv;                            // [RULE_14]
      end
   end

   // fuse state registers; reset gives the unprogrammed image [RULE_13]
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         nv <= '{osc_source_sel: `CFB_DEF_OSC_SEL,
                 brownout_threshold_sel: `CFB_DEF_THR,
                 brownout_mode_sel: `CFB_DEF_MODE,
                 powerup_timer_off_n: 1'b1, block1_guard: 1'b1,
                 block0_guard: 1'b1, boot_block_guard: 1'b1,
                 config_area_guard: 1'b1, default: 1'b0};
         act <= '{osc_source_sel: `CFB_DEF_OSC_SEL,
                  brownout_threshold_sel: `CFB_DEF_THR,
                  brownout_mode_sel: `CFB_DEF_MODE,
                  powerup_timer_off_n: 1'b1, block1_guard: 1'b1,
                  block0_guard: 1'b1, boot_block_guard: 1'b1,
                  config_area_guard: 1'b1, default: 1'b0};
         load_pend <= 1'b1;
         soft_brownout_on <= `CFB_DEF_SBO;
         prog_mode <= 1'b0;
      end else begin
         nv <= next_nv;
         act <= next_act;
         load_pend <= next_load_pend;
         soft_brownout_on <= next_soft_brownout_on;
         prog_mode <= next_prog_mode;
      end
   end

   // read mux: unused bit positions stay zero [RULE_12]
   always_comb begin
      rd_byte = 8'h00;
      hit = 1'b1;
      unique case (paddr)
         `CFB_ADDR(`CFB_IDX_OSC): begin
            rd_byte[`CFB_OSC_SWO_BIT] = nv.osc_switchover_on;
            rd_byte[`CFB_OSC_FCM_BIT] = nv.clock_monitor_on;
            rd_byte[`CFB_OSC_SEL_LSB +: 4] = nv.osc_source_sel;
         end
         `CFB_ADDR(`CFB_IDX_REGBP): begin
            rd_byte[`CFB_RB_VREG_BIT] = nv.usb_regulator_on;
            rd_byte[`CFB_RB_THR_LSB +: 2] = nv.brownout_threshold_sel;
            rd_byte[`CFB_RB_MODE_LSB +: 2] = nv.brownout_mode_sel;
            rd_byte[`CFB_RB_POWERUP_TIMER_BIT] = nv.powerup_timer_off_n;
         end
         `CFB_ADDR(`CFB_IDX_WPLO): begin
            rd_byte[`CFB_WP_B1_BIT] = nv.block1_guard;
            rd_byte[`CFB_WP_B0_BIT] = nv.block0_guard;
         end
         `CFB_ADDR(`CFB_IDX_WPHI): begin
            rd_byte[`CFB_WP_BOOT_BIT] = nv.boot_block_guard;
            rd_byte[`CFB_WP_CFG_BIT] = nv.config_area_guard;
         end
         `CFB_ADDR(`CFB_IDX_CTRL): begin
            rd_byte[`CFB_CTRL_SBO_BIT] = soft_brownout_on;
         end
         `CFB_ADDR(`CFB_IDX_STAT): begin
            // live state of the block, not the stored image
            rd_byte[`CFB_STAT_BOR_BIT] = brownout_reset_on;
            rd_byte[`CFB_STAT_PWR_BIT] = powerup_timer_on;
            rd_byte[`CFB_STAT_PRG_BIT] = prog_mode;
            rd_byte[`CFB_STAT_VLD_BIT] = fuses_valid;
         end
         default: begin
            hit = 1'b0;                            // unmapped: error, zero
         end
      endcase
   end

   // apb answer group
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;

   // answer is built in setup and shown through the access cycle
   always_comb begin
      next_pready = setup;
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (setup) begin
         next_prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         next_pslverr = !hit;
      end
   end

   // apb answer registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // decoded device controls, taken from the latched copy; brown-out also follows soft_brownout_on and in_sleep
   cfb_pkg::cfb_src_t next_cpu_src, next_usb_src;
   logic       next_vreg, next_bor, next_powerup_timer;
   logic [1:0] next_trip;
   logic       next_done, next_allow;
   logic       blk;
   logic [21:0] b0_lo;

   // clock source and power decode
   always_comb begin
      // usb kind from the primary field, core kind may be internal
      if (act.osc_source_sel[3:2] == 2'b10) begin
         // core on internal, usb stays on the primary source [RULE_02]
         next_cpu_src = cfb_pkg::CFB_SRC_INTERNAL;
         unique case (act.osc_source_sel[1:0])
            2'b11: next_usb_src = cfb_pkg::CFB_SRC_FAST_CRYSTAL;
            2'b10: next_usb_src = cfb_pkg::CFB_SRC_CRYSTAL;
            default: next_usb_src = cfb_pkg::CFB_SRC_EXTERNAL;
         endcase
      end else begin
         // both share the selected primary oscillator [RULE_01]
         if (act.osc_source_sel[3]) begin
            next_usb_src = cfb_pkg::CFB_SRC_FAST_CRYSTAL;
         end else if (act.osc_source_sel[2]) begin
            next_usb_src = cfb_pkg::CFB_SRC_EXTERNAL;
         end else begin
            next_usb_src = cfb_pkg::CFB_SRC_CRYSTAL;
         end
         next_cpu_src = next_usb_src;
      end
      next_vreg = act.usb_regulator_on;            // [RULE_03]
      // level 0 is the minimum trip, 3 the maximum [RULE_04]
      next_trip = ~act.brownout_threshold_sel;
      unique case (act.brownout_mode_sel)
         2'b11: next_bor = 1'b1;
         2'b10: next_bor = !in_sleep;
         2'b01: next_bor = soft_brownout_on;      // [RULE_05]
         2'b00: next_bor = 1'b0;                  // [RULE_06]
      endcase
      // timer depends only on its own bit [RULE_07] [RULE_08]
      next_powerup_timer = !act.powerup_timer_off_n;
   end

   // program-memory write guard
   always_comb begin
      b0_lo = boot_block_large ? `CFB_B0_LO_LARGE : `CFB_B0_LO_SMALL;
      blk = 1'b0;
      if (prog_wr_addr >= `CFB_B1_LO && prog_wr_addr <= `CFB_B1_HI &&
          !act.block1_guard) begin
         blk = 1'b1;                               // [RULE_09]
      end
      if (prog_wr_addr >= b0_lo && prog_wr_addr <= `CFB_B0_HI &&
          !act.block0_guard) begin
         blk = 1'b1;                               // [RULE_10]
      end
      if (prog_wr_addr < b0_lo && !act.boot_block_guard) begin
         blk = 1'b1;
      end
      if (prog_wr_addr[21:8] == `CFB_CFG_PAGE && !act.config_area_guard) begin
         blk = 1'b1;
      end
      next_done = prog_wr_req;
      next_allow = prog_wr_req && !blk;
   end

   // device output registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cpu_clk_src <= cfb_pkg::CFB_SRC_CRYSTAL;
         usb_clk_src <= cfb_pkg::CFB_SRC_CRYSTAL;
         usb_regulator_on <= 1'b0;
         brownout_trip_level <= 2'h0;
         brownout_reset_on <= 1'b0;
         powerup_timer_on <= 1'b0;
         osc_switchover_on <= 1'b0;
         clock_monitor_on <= 1'b0;
         fuses_valid <= 1'b0;
         prog_wr_done <= 1'b0;
         prog_wr_allow <= 1'b0;
      end else begin
         cpu_clk_src <= next_cpu_src;
         usb_clk_src <= next_usb_src;
         usb_regulator_on <= next_vreg;
         brownout_trip_level <= next_trip;
         brownout_reset_on <= next_bor;
         powerup_timer_on <= next_powerup_timer;
         osc_switchover_on <= act.osc_switchover_on;
         clock_monitor_on <= act.clock_monitor_on;
         // outputs trustworthy once the first copy has landed
         fuses_valid <= !load_pend;
         prog_wr_done <= next_done;
         prog_wr_allow <= next_allow;
      end
   end

endmodule

/* File: core/cfb_defs.svh */
// constants for the configuration fuse bank: register indices, field
// positions and unprogrammed defaults.
// assumes the includer owns the namespace of the CFB_ macro prefix.
`ifndef CFB_DEFS_SVH
`define CFB_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define CFB_IDX_OSC      24'h300001
`define CFB_IDX_REGBP    24'h300002
`define CFB_IDX_WPLO     24'h30000A
`define CFB_IDX_WPHI     24'h30000B
`define CFB_IDX_CTRL     24'h300010
`define CFB_IDX_STAT     24'h300011
`define CFB_ADDR(idx)    ((idx) << 2)

// oscillator select byte
`define CFB_OSC_SWO_BIT  7
`define CFB_OSC_FCM_BIT  6
`define CFB_OSC_SEL_LSB  0
// regulator / brown-out / power-up byte
`define CFB_RB_VREG_BIT  5
`define CFB_RB_THR_LSB   3
`define CFB_RB_MODE_LSB  1
`define CFB_RB_POWERUP_TIMER_BIT  0
// block write protect bytes
`define CFB_WP_B1_BIT    1
`define CFB_WP_B0_BIT    0
`define CFB_WP_BOOT_BIT  6
`define CFB_WP_CFG_BIT   5
// own control / status bytes
`define CFB_CTRL_SBO_BIT 0
`define CFB_STAT_BOR_BIT 0
`define CFB_STAT_PWR_BIT 1
`define CFB_STAT_PRG_BIT 2
`define CFB_STAT_VLD_BIT 3

// unprogrammed values
`define CFB_DEF_OSC_SEL  4'h7
`define CFB_DEF_THR      2'h3
`define CFB_DEF_MODE     2'h3
`define CFB_DEF_SBO      1'b1

// program address ranges (22-bit word space)
`define CFB_B1_LO        22'h002000
`define CFB_B1_HI        22'h003FFF
`define CFB_B0_LO_SMALL  22'h000800
`define CFB_B0_LO_LARGE  22'h001000
`define CFB_B0_HI        22'h001FFF
`define CFB_CFG_PAGE     14'h3000
`endif

/* File: core/cfb_pkg.sv */
// types shared by the configuration fuse bank.
// assumes nothing beyond a SystemVerilog compiler.
package cfb_pkg;
   // clock source kinds seen by the core and the usb module
   typedef enum logic [1:0] {
      CFB_SRC_CRYSTAL,
      CFB_SRC_FAST_CRYSTAL,
      CFB_SRC_EXTERNAL,
      CFB_SRC_INTERNAL
   } cfb_src_t;

   // one full set of fuse fields
   typedef struct packed {
      logic       osc_switchover_on;
      logic       clock_monitor_on;
      logic [3:0] osc_source_sel;
      logic       usb_regulator_on;
      logic [1:0] brownout_threshold_sel;
      logic [1:0] brownout_mode_sel;
      logic       powerup_timer_off_n;
      logic       block1_guard;
      logic       block0_guard;
      logic       boot_block_guard;
      logic       config_area_guard;
   } cfb_fuse_t;
endpackage

/* File: verification/cfb_fuse_chk.sv */
// port assertions for the configuration fuse bank.
// assumes it is bound onto cfb_fuse_bank, one clock, async low reset.
`timescale 1ns/1ns
`include "cfb_defs.svh"
module cfb_fuse_chk (
   input wire logic              sys_clk,
   input wire logic              rstn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [23:0]       paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              prog_wr_req,
   input wire logic              prog_wr_done,
   input wire logic              prog_wr_allow,
   input wire cfb_pkg::cfb_src_t cpu_clk_src,
   input wire cfb_pkg::cfb_src_t usb_clk_src,
   input wire logic              fuses_valid
);
   // byte address of the regulator / brown-out byte
   localparam logic [23:0] RB_A = `CFB_ADDR(`CFB_IDX_REGBP);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // bus steps
   sequence s_setup; psel && !penable; endsequence
   sequence s_read; pready && !pwrite; endsequence
   property p_answer; s_setup |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no ready after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready held too long");
   property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero)
      else $error("error read not zero");
   property p_hi_zero; s_read |-> prdata[31:8] == 24'h0; endproperty
   a_hi_zero: assert property (p_hi_zero)
      else $error("upper read bits set");
   property p_rb_zero; s_read and paddr == RB_A |-> prdata[7:6] == 2'h0;
   endproperty
   a_rb_zero: assert property (p_rb_zero)
      else $error("unused bits set");
   property p_unmapped; pready && paddr == 24'h000000 |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no slave error");
   property p_allow; prog_wr_allow |-> prog_wr_done; endproperty
   a_allow: assert property (p_allow)
      else $error("allow without done");
   property p_done;
      prog_wr_req ##1 !prog_wr_req |-> prog_wr_done ##1 !prog_wr_done;
   endproperty
   a_done: assert property (p_done) else $error("write check answer");
   property p_usb; fuses_valid |-> usb_clk_src != cfb_pkg::CFB_SRC_INTERNAL;
   endproperty
   a_usb: assert property (p_usb)
      else $error("usb on internal clock");
   property p_share;
      fuses_valid && cpu_clk_src != cfb_pkg::CFB_SRC_INTERNAL
         |-> usb_clk_src == cpu_clk_src;
   endproperty
   a_share: assert property (p_share)
      else $error("usb and core sources differ");
   property p_hold; fuses_valid |=> fuses_valid; endproperty
   a_hold: assert property (p_hold)
      else $error("fuse copy dropped");
   property p_valid; $rose(rstn) |-> ##[1:3] fuses_valid; endproperty
   a_valid: assert property (p_valid)
      else $error("fuses not loaded");
endmodule

/* File: verification/tb.sv */
// self-checking bench for the configuration fuse bank.
// assumes the fuse bank and its checker are compiled beforehand.
`timescale 1ns/1ns
`include "cfb_defs.svh"
module tb;
   logic        sys_clk, rstn, psel, penable, pwrite;
   logic [23:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, prog_mode_pin, in_sleep, boot_block_large;
   logic        prog_wr_req, prog_wr_done, prog_wr_allow, usb_regulator_on;
   logic [21:0] prog_wr_addr;
   logic [1:0]  brownout_trip_level;
   logic        brownout_reset_on, powerup_timer_on, fuses_valid;
   logic        osc_switchover_on, clock_monitor_on;
   cfb_pkg::cfb_src_t cpu_clk_src, usb_clk_src;
   int          mismatches, checked;
   // byte addresses of the registers
   localparam logic [23:0] A_OS = `CFB_ADDR(`CFB_IDX_OSC);
   localparam logic [23:0] A_RB = `CFB_ADDR(`CFB_IDX_REGBP);
   localparam logic [23:0] A_WL = `CFB_ADDR(`CFB_IDX_WPLO);
   localparam logic [23:0] A_WH = `CFB_ADDR(`CFB_IDX_WPHI);
   localparam logic [23:0] A_CT = `CFB_ADDR(`CFB_IDX_CTRL);
   localparam logic [23:0] A_ST = `CFB_ADDR(`CFB_IDX_STAT);
   cfb_fuse_bank dut_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_mode_pin(prog_mode_pin), .in_sleep(in_sleep),
      .boot_block_large(boot_block_large), .prog_wr_req(prog_wr_req),
      .prog_wr_addr(prog_wr_addr), .prog_wr_done(prog_wr_done),
      .prog_wr_allow(prog_wr_allow), .cpu_clk_src(cpu_clk_src),
      .usb_clk_src(usb_clk_src), .usb_regulator_on(usb_regulator_on),
      .brownout_trip_level(brownout_trip_level),
      .brownout_reset_on(brownout_reset_on),
      .powerup_timer_on(powerup_timer_on),
      .osc_switchover_on(osc_switchover_on),
      .clock_monitor_on(clock_monitor_on), .fuses_valid(fuses_valid));
   // 50 mhz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // port level comparison
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e,
                       input string w);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, w, g, e);
      end
   endtask
   // read data comparison
   task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %0t read got %h exp %h", $time, g, e);
      end
   endtask
   // one apb transfer; waits for pready, a hang is left to the watchdog
   task automatic apb(input logic w, input logic [23:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [23:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [23:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      cmp32(q, x);
   endtask
   // fuse write inside a programming-mode window; reload on exit
   task automatic burn(input logic [23:0] a, input logic [7:0] v);
      prog_mode_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      wr(a, {24'h0, v});
      prog_mode_pin <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask
   // program write check; answer taken at the edge where done is seen
   task automatic pw(input logic [21:0] a, input logic e);
      @(posedge sys_clk);
      prog_wr_req <= 1'b1;
      prog_wr_addr <= a;
      @(posedge sys_clk);
      prog_wr_req <= 1'b0;
      do begin
         @(posedge sys_clk);
      end while (prog_wr_done !== 1'b1);
      cmp8({7'h0, prog_wr_allow}, {7'h0, e}, "allow");
   endtask
   task automatic t_defaults;
      rd(A_OS, 32'h07);
      rd(A_RB, 32'h1F);
      rd(A_WL, 32'h03);
      rd(A_WH, 32'h60);
      rd(A_CT, 32'h01);
      rd(A_ST, 32'h09);
      cmp8({6'h0, cpu_clk_src}, 8'h02, "cpu");
      cmp8({6'h0, brownout_trip_level}, 8'h00, "trip");
      cmp8({7'h0, powerup_timer_on}, 8'h00, "timer");
      cmp8({7'h0, usb_regulator_on}, 8'h00, "reg");
   endtask
   // writes outside programming mode and a read from no register
   task automatic t_refused;
      logic [31:0] q;
      logic        e;
      wr(A_RB, 32'h20);
      rd(A_RB, 32'h1F);
      wr(A_WH, 32'h00);
      rd(A_WH, 32'h60);
      apb(1'b0, 24'h000000, 32'h0, q, e);
      cmp8({7'h0, e}, 8'h01, "slverr");
      cmp32(q, 32'h0);
   endtask
   // store changes, outputs wait for the end of programming
   task automatic t_latch;
      prog_mode_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      wr(A_RB, 32'hE1);
      repeat (4) @(posedge sys_clk);
      cmp8({7'h0, usb_regulator_on}, 8'h00, "held");
      prog_mode_pin <= 1'b0;
      repeat (8) @(posedge sys_clk);
      cmp8({7'h0, usb_regulator_on}, 8'h01, "reg");
      rd(A_RB, 32'h21);
   endtask
   // brown-out modes against soft enable and sleep
   task automatic t_bor;
      logic [7:0] rb [6] = '{8'h22, 8'h22, 8'h01, 8'h0C, 8'h0C, 8'h17};
      logic       sb [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      logic       sl [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      logic       bo [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 6; i++) begin
         burn(A_RB, rb[i]);
         wr(A_CT, {31'h0, sb[i]});
         in_sleep <= sl[i];
         repeat (4) @(posedge sys_clk);
         cmp8({7'h0, brownout_reset_on}, {7'h0, bo[i]}, "bor");
         cmp8({6'h0, brownout_trip_level}, {6'h0, ~rb[i][4:3]}, "trip");
         cmp8({7'h0, powerup_timer_on}, {7'h0, ~rb[i][0]}, "timer");
         cmp8({7'h0, usb_regulator_on}, {7'h0, rb[i][5]}, "reg");
      end
   endtask
   // source codes packed as core then usb
   task automatic t_osc;
      logic [3:0] os [6] = '{4'h0, 4'h4, 4'hC, 4'hB, 4'hA, 4'h8};
      logic [3:0] ex [6] = '{4'h0, 4'hA, 4'h5, 4'hD, 4'hC, 4'hE};
      for (int i = 0; i < 6; i++) begin
         burn(A_OS, {4'h0, os[i]});
         cmp8({6'h0, cpu_clk_src}, {6'h0, ex[i][3:2]}, "cpu");
         cmp8({6'h0, usb_clk_src}, {6'h0, ex[i][1:0]}, "usb");
      end
      // unused bits written high must read back low
      burn(A_OS, 8'hF7);
      rd(A_OS, 32'hC7);
      cmp8({6'h0, osc_switchover_on, clock_monitor_on}, 8'h03,
           "osc");
   endtask
   // block guards at range edges, clear only
   task automatic t_guard;
      boot_block_large <= 1'b0;
      pw(22'h000800, 1'b1);
      pw(22'h002000, 1'b1);
      burn(A_WL, 8'h00);
      pw(22'h002000, 1'b0);
      pw(22'h003FFF, 1'b0);
      pw(22'h004000, 1'b1);
      pw(22'h000800, 1'b0);
      pw(22'h001FFF, 1'b0);
      boot_block_large <= 1'b1;
      pw(22'h000800, 1'b1);
      pw(22'h001000, 1'b0);
      burn(A_WL, 8'h03);
      rd(A_WL, 32'h00);
      burn(A_WH, 8'h40);
      rd(A_WH, 32'h40);
   endtask
   // main sequence
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 24'h0;
      pwdata = 32'h0;
      prog_mode_pin = 1'b0;
      in_sleep = 1'b0;
      boot_block_large = 1'b0;
      prog_wr_req = 1'b0;
      prog_wr_addr = 22'h0;
      mismatches = 0;
      checked = 0;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_defaults;
      t_refused;
      t_latch;
      t_bor;
      t_osc;
      t_guard;
      complete_run;
   end
   // watchdog, well past the expected run
   initial begin
      #400000;
      cmp8(8'h0, 8'h1, "watchdog");
      complete_run;
   end
endmodule
bind cfb_fuse_bank cfb_fuse_chk chk_u (.sys_clk(sys_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .prog_wr_req(prog_wr_req), .prog_wr_done(prog_wr_done),
   .prog_wr_allow(prog_wr_allow), .cpu_clk_src(cpu_clk_src),
   .usb_clk_src(usb_clk_src), .fuses_valid(fuses_valid));
